// ### rtl/mac_serial_pkg.sv
// Shared constants and carrier types for the MAC serial NRZ port.
// Assumes a 20 MHz oscillator clock and a 32-bit classic Wishbone register bus.
package mac_serial_pkg;

  // Clock and timing
  localparam int unsigned OSC_HZ = 20_000_000;
  localparam int unsigned TX_CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TX_HALF_CYC = OSC_HZ / TX_CLK_HZ / 2;
  localparam int unsigned CRS_HOLD_NS = 150;
  localparam int unsigned CRS_HOLD_CYC = (CRS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RXC_TAIL_NS = 500;
  localparam int unsigned RXC_TAIL_CYC = RXC_TAIL_NS / CLK_PERIOD_NS;
  localparam int unsigned BYTE_BITS = 8;

  // Register byte addresses
  localparam logic [7:0] ADR_CFG = 8'h00;
  localparam logic [7:0] ADR_CFG2 = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;

  // Field positions
  localparam int unsigned CFG_EXT_BUS_BIT = 0;
  localparam int unsigned CFG2_USER0_BIT = 0;
  localparam int unsigned CFG2_USER1_BIT = 1;
  localparam int unsigned CFG2_USER3_BIT = 2;
  localparam int unsigned ST_CARRIER_BIT = 0;
  localparam int unsigned ST_TX_ACTIVE_BIT = 1;
  localparam int unsigned ST_EXT_STRAP_BIT = 2;
  localparam int unsigned ST_WRITTEN_BIT = 3;
  localparam int unsigned ST_BUS_MODE_STRAP_BIT = 4;

  // Values after reset
  localparam logic CFG_EXT_BUS_RST = 1'b0;
  localparam logic [2:0] CFG2_USER_RST = 3'h0;

  typedef struct packed {
    logic value;
    logic enable;
  } pin_drive_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } rx_byte_t;

  typedef struct packed {
    logic carrier;
    logic clk;
    logic data;
    logic bit_stb;
  } codec_rx_t;

endpackage

// ### rtl/manchester_rx.sv
// On-chip receive decoder: carrier sense, recovered clock and NRZ data.
// Assumes the line input is already synchronised to clk_i, one sample per half bit.
`timescale 1ns/10ps
module manchester_rx (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic line_i,
  output mac_serial_pkg::codec_rx_t rx_o
);
  localparam logic [3:0] HOLD_LAST = 4'(mac_serial_pkg::CRS_HOLD_CYC - 1);
  localparam logic [3:0] TAIL_LEN = 4'(mac_serial_pkg::RXC_TAIL_CYC);

  logic line_prev_reg;
  logic [3:0] idle_reg;
  logic [3:0] tail_reg;
  logic phase_reg;
  logic carrier_reg;
  logic rclk_reg;
  logic data_reg;
  logic stb_reg;
  logic fall;
  logic trans;

  assign fall = line_prev_reg & ~line_i;
  assign trans = line_prev_reg ^ line_i;
  assign rx_o = '{carrier: carrier_reg, clk: rclk_reg, data: data_reg, bit_stb: stb_reg};

  // Previous line sample for edge finding
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      line_prev_reg <= 1'b0;
    else
      line_prev_reg <= line_i;
  end

  // Carrier: on at first falling edge, off after a silent hold window
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      carrier_reg <= 1'b0;
      idle_reg <= 4'h0;
    end
    else if (!carrier_reg && fall)
    begin
      carrier_reg <= 1'b1; // [R14]
      idle_reg <= 4'h0;
    end
    else if (carrier_reg)
    begin
      if (trans)
        idle_reg <= 4'h0;
      else if (idle_reg == HOLD_LAST)
        carrier_reg <= 1'b0; // [R14]
      else
        idle_reg <= idle_reg + 4'h1;
    end
  end

  // Recovered clock; data moves on the low phase so it is steady at the rise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_reg <= 1'b0;
      rclk_reg <= 1'b0;
      data_reg <= 1'b0;
      stb_reg <= 1'b0;
      tail_reg <= 4'h0;
    end
    else
    begin
      stb_reg <= 1'b0;
      if (!carrier_reg && fall)
      begin
        phase_reg <= 1'b1;
        rclk_reg <= 1'b0;
        data_reg <= line_i;
        stb_reg <= 1'b1;
        tail_reg <= TAIL_LEN;
      end
      else if (carrier_reg || tail_reg != 4'h0)
      begin
        // Keeps running after carrier drops so the MAC can flush
        tail_reg <= carrier_reg ? TAIL_LEN : tail_reg - 4'h1; // [R3]
        phase_reg <= ~phase_reg;
        if (phase_reg)
          rclk_reg <= 1'b1;
        else
        begin
          rclk_reg <= 1'b0;
          data_reg <= line_i; // [R1]
          stb_reg <= carrier_reg;
        end
      end
      else
        rclk_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_tail_toggles;
    (rclk_reg != $past(rclk_reg)) [*8];
  endsequence

  property p_crs_rise;
    !carrier_reg && fall |=> carrier_reg;
  endproperty
  a_crs_rise: assert property (p_crs_rise) else $error("carrier missed first fall"); // [R14]

  property p_crs_hold;
    carrier_reg && trans |=> carrier_reg [*2];
  endproperty
  a_crs_hold: assert property (p_crs_hold) else $error("carrier dropped early"); // [R14]

  property p_rxc_tail;
    $fell(carrier_reg) |-> ##1 s_tail_toggles;
  endproperty
  a_rxc_tail: assert property (p_rxc_tail) else $error("recovered clock stopped early"); // [R3]

  property p_rxd_at_rise;
    $rose(rclk_reg) |-> $stable(data_reg);
  endproperty
  a_rxd_at_rise: assert property (p_rxd_at_rise) else $error("rx data moved at clock rise"); // [R1]

endmodule

// ### rtl/mac_serial_port.sv
// MAC serial NRZ port: pin muxing, transmit timing, receive capture, Wishbone regs.
// Assumes straps are fixed, rx_link_clk_i is the receive clock pin's input and
// bus_master_i comes from the DMA logic on clk_i.
// Behaviour
// [R1] Internal receive data sampled at clock rise
// [R2] External receive data captured on clock rise
// [R3] Recovered clock runs five bits after carrier
// [R4] Transmit bit steady at transmit clock rise
// [R5] Transmit enable high through last byte
// [R6] Internal transmit clock is oscillator divided
// [R7] External transmit clock shifts serializer data
// [R8] Port pins float until config written
// [R9] Extended option: user outputs when bus master
// [R10] Termination input sampled while bus master
// [R11] Termination used only in asynchronous bus mode
// [R12] Internal codec signals also driven on pins
// [R13] Strap selects internal or external pin roles
// [R14] Carrier on first fall, holds 1.5 bits
// [R15] Board keeps codec strap fixed
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
module mac_serial_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_link_clk_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_codec_strap_i,
  input wire logic bus_mode_strap_i,
  input wire logic bus_master_i,
  input wire logic line_rx_i,
  input wire logic rx_data_pin_i,
  output logic rx_data_pin_o,
  output logic rx_data_pin_oe_o,
  output logic rx_clk_pin_o,
  output logic rx_clk_pin_oe_o,
  output logic tx_data_pin_o,
  output logic tx_data_pin_oe_o,
  input wire logic tx_clk_pin_i,
  output logic tx_clk_pin_o,
  output logic tx_clk_pin_oe_o,
  output logic tx_active_o,
  output logic carrier_sense_out_o,
  output logic sync_cycle_terminate_o,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_last_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o
);
  localparam logic [3:0] TX_HALF_LAST = 4'(mac_serial_pkg::TX_HALF_CYC - 1);
  localparam logic [2:0] BIT_LAST = 3'(mac_serial_pkg::BYTE_BITS - 1);

  logic ext_strap_s1_reg, bus_mode_strap_strap_s1_reg;
  logic ext_strap_reg;
  logic bus_mode_strap_strap_reg;
  logic line_s1_reg, line_s2_reg;
  logic txc_s1_reg, txc_s2_reg, txc_s3_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic cfg_ext_bus_reg;
  logic cfg_written_reg;
  logic [2:0] user_reg;
  logic [3:0] div_cnt_reg;
  logic tx_clk_reg;
  logic [7:0] hold_data_reg;
  logic hold_last_reg, hold_valid_reg, tx_ready_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic last_reg, tx_data_reg, tx_active_reg;
  logic [7:0] rx_shift_reg;
  logic [2:0] rx_cnt_reg;
  mac_serial_pkg::rx_byte_t rx_out_reg;
  logic rst_l1_reg, rst_l2_reg;
  logic [7:0] link_shift_reg, link_byte_reg;
  logic [2:0] link_cnt_reg;
  logic link_tog_reg;
  logic tog_s1_reg, tog_s2_reg, tog_s3_reg;
  mac_serial_pkg::pin_drive_t rxd_pin_reg, rxc_pin_reg, txd_pin_reg, txc_pin_reg;
  logic sync_cycle_terminate_reg, crs_out_reg;
  mac_serial_pkg::codec_rx_t dec;
  logic req, div_last, tx_tick;

  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign div_last = (div_cnt_reg == TX_HALF_LAST);
  // Internal: act just before the divided clock falls; external: on the sampled rise
  assign tx_tick = ext_strap_reg ? (~cfg_ext_bus_reg & txc_s2_reg & ~txc_s3_reg) // [R7]
                                 : (tx_clk_reg & div_last); // [R4]

  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;
  assign rx_data_pin_o = rxd_pin_reg.value;
  assign rx_data_pin_oe_o = rxd_pin_reg.enable;
  assign rx_clk_pin_o = rxc_pin_reg.value;
  assign rx_clk_pin_oe_o = rxc_pin_reg.enable;
  assign tx_data_pin_o = txd_pin_reg.value;
  assign tx_data_pin_oe_o = txd_pin_reg.enable;
  assign tx_clk_pin_o = txc_pin_reg.value;
  assign tx_clk_pin_oe_o = txc_pin_reg.enable;
  assign tx_active_o = tx_active_reg;
  assign tx_ready_o = tx_ready_reg;
  assign carrier_sense_out_o = crs_out_reg;
  assign sync_cycle_terminate_o = sync_cycle_terminate_reg;
  assign rx_byte_o = rx_out_reg.data;
  assign rx_valid_o = rx_out_reg.valid;

  // Straps caught while reset is held; they never change afterwards
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_strap_reg <= ext_strap_s1_reg; // [R13] [R15]
      bus_mode_strap_strap_reg <= bus_mode_strap_strap_s1_reg;
    end
  end

  // Pin synchronisers; straps are taken from stage one, the other pins from stages two and three
  always_ff @(posedge clk_i)
  begin
    ext_strap_s1_reg <= external_codec_strap_i;
    bus_mode_strap_strap_s1_reg <= bus_mode_strap_i;
    line_s1_reg <= line_rx_i;
    line_s2_reg <= line_s1_reg;
    txc_s1_reg <= tx_clk_pin_i;
    txc_s2_reg <= txc_s1_reg;
    txc_s3_reg <= txc_s2_reg;
    tog_s1_reg <= link_tog_reg;
    tog_s2_reg <= tog_s1_reg;
    tog_s3_reg <= tog_s2_reg;
  end

  manchester_rx u_dec (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .line_i(line_s2_reg),
    .rx_o(dec)
  );

  // Wishbone answer one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= req;
      dat_reg <= 32'h0000_0000;
      if (req && !wb_we_i)
      begin
        case (wb_adr_i)
          mac_serial_pkg::ADR_CFG:
            dat_reg[mac_serial_pkg::CFG_EXT_BUS_BIT] <= cfg_ext_bus_reg;
          mac_serial_pkg::ADR_CFG2:
            dat_reg[2:0] <= user_reg;
          mac_serial_pkg::ADR_STATUS:
          begin
            dat_reg[mac_serial_pkg::ST_CARRIER_BIT] <= dec.carrier;
            dat_reg[mac_serial_pkg::ST_TX_ACTIVE_BIT] <= tx_active_reg;
            dat_reg[mac_serial_pkg::ST_EXT_STRAP_BIT] <= ext_strap_reg;
            dat_reg[mac_serial_pkg::ST_WRITTEN_BIT] <= cfg_written_reg;
            dat_reg[mac_serial_pkg::ST_BUS_MODE_STRAP_BIT] <= bus_mode_strap_strap_reg;
          end
          default:
            dat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Config writes land with the ack; lane 0 only, unmapped writes dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_ext_bus_reg <= mac_serial_pkg::CFG_EXT_BUS_RST;
      cfg_written_reg <= 1'b0;
      user_reg <= mac_serial_pkg::CFG2_USER_RST;
    end
    else if (ack_reg && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == mac_serial_pkg::ADR_CFG)
      begin
        cfg_ext_bus_reg <= wb_dat_i[mac_serial_pkg::CFG_EXT_BUS_BIT];
        cfg_written_reg <= 1'b1; // [R8]
      end
      else if (wb_adr_i == mac_serial_pkg::ADR_CFG2)
        user_reg <= wb_dat_i[2:0];
    end
  end

  // Divide the oscillator down to the transmit clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_cnt_reg <= 4'h0;
      tx_clk_reg <= 1'b0;
    end
    else if (div_last)
    begin
      div_cnt_reg <= 4'h0;
      tx_clk_reg <= ~tx_clk_reg; // [R6]
    end
    else
      div_cnt_reg <= div_cnt_reg + 4'h1;
  end

  // Transmit serializer, LSB first, one byte held ahead to avoid gaps
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_data_reg <= 8'h00;
      hold_last_reg <= 1'b0;
      hold_valid_reg <= 1'b0;
      tx_ready_reg <= 1'b0;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      last_reg <= 1'b0;
      tx_data_reg <= 1'b0;
      tx_active_reg <= 1'b0;
    end
    else
    begin
      if (!hold_valid_reg && !tx_ready_reg)
        tx_ready_reg <= 1'b1;
      if (tx_valid_i && tx_ready_reg)
      begin
        hold_data_reg <= tx_byte_i;
        hold_last_reg <= tx_last_i;
        hold_valid_reg <= 1'b1;
        tx_ready_reg <= 1'b0;
      end
      if (tx_tick)
      begin
        if (bit_cnt_reg != 3'h0)
        begin
          tx_data_reg <= shift_reg[1]; // [R4]
          shift_reg <= shift_reg >> 1;
          bit_cnt_reg <= bit_cnt_reg - 3'h1;
        end
        else if (hold_valid_reg && !(tx_active_reg && last_reg))
        begin
          shift_reg <= hold_data_reg;
          tx_data_reg <= hold_data_reg[0];
          bit_cnt_reg <= BIT_LAST;
          last_reg <= hold_last_reg;
          tx_active_reg <= 1'b1; // [R5]
          hold_valid_reg <= 1'b0;
        end
        else
        begin
          // Frame's last bit has had its full cell
          tx_active_reg <= 1'b0; // [R5]
          tx_data_reg <= 1'b0;
          last_reg <= 1'b0;
        end
      end
    end
  end

  // Link-side reset follows rst_i through two stages
  always_ff @(posedge rx_link_clk_i)
  begin
    rst_l1_reg <= rst_i;
    rst_l2_reg <= rst_l1_reg;
  end

  // External decoder data taken on the receive clock's rise
  always_ff @(posedge rx_link_clk_i)
  begin
    if (rst_l2_reg)
    begin
      link_shift_reg <= 8'h00;
      link_cnt_reg <= 3'h0;
      link_byte_reg <= 8'h00;
      link_tog_reg <= 1'b0;
    end
    else
    begin
      link_shift_reg <= {rx_data_pin_i, link_shift_reg[7:1]}; // [R2]
      link_cnt_reg <= link_cnt_reg + 3'h1;
      if (link_cnt_reg == BIT_LAST)
      begin
        // Byte stays put for eight link clocks, ample for the toggle to cross
        link_byte_reg <= {rx_data_pin_i, link_shift_reg[7:1]};
        link_tog_reg <= ~link_tog_reg;
      end
    end
  end

  // Receive bytes to the MAC from whichever decoder the strap picked
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_shift_reg <= 8'h00;
      rx_cnt_reg <= 3'h0;
      rx_out_reg <= '{data: 8'h00, valid: 1'b0};
    end
    else
    begin
      rx_out_reg.valid <= 1'b0;
      if (ext_strap_reg)
      begin
        if (tog_s2_reg ^ tog_s3_reg)
          rx_out_reg <= '{data: link_byte_reg, valid: 1'b1}; // [R2]
      end
      else if (!dec.carrier)
        rx_cnt_reg <= 3'h0;
      else if (dec.bit_stb)
      begin
        rx_shift_reg <= {dec.data, rx_shift_reg[7:1]}; // [R1] [R12]
        rx_cnt_reg <= rx_cnt_reg + 3'h1;
        if (rx_cnt_reg == BIT_LAST)
          rx_out_reg <= '{data: {dec.data, rx_shift_reg[7:1]}, valid: 1'b1};
      end
    end
  end

  // Pin roles from strap, config written flag and extended option
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !cfg_written_reg)
    begin
      rxd_pin_reg <= '{value: 1'b0, enable: 1'b0}; // [R8]
      rxc_pin_reg <= '{value: 1'b0, enable: 1'b0};
      txd_pin_reg <= '{value: 1'b0, enable: 1'b0};
      txc_pin_reg <= '{value: 1'b0, enable: 1'b0};
    end
    else if (cfg_ext_bus_reg)
    begin
      rxd_pin_reg <= '{value: user_reg[mac_serial_pkg::CFG2_USER0_BIT], enable: bus_master_i}; // [R9]
      rxc_pin_reg <= '{value: user_reg[mac_serial_pkg::CFG2_USER1_BIT], enable: bus_master_i};
      txd_pin_reg <= '{value: user_reg[mac_serial_pkg::CFG2_USER3_BIT], enable: bus_master_i};
      txc_pin_reg <= '{value: 1'b0, enable: 1'b0};
    end
    else
    begin
      txd_pin_reg <= '{value: tx_data_reg, enable: 1'b1};
      rxd_pin_reg <= '{value: dec.data, enable: ~ext_strap_reg}; // [R12] [R13]
      rxc_pin_reg <= '{value: dec.clk, enable: ~ext_strap_reg}; // [R12]
      txc_pin_reg <= '{value: tx_clk_reg, enable: ~ext_strap_reg}; // [R6]
    end
  end

  // Carrier to the user; termination sampled only as master in async mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      crs_out_reg <= 1'b0;
      sync_cycle_terminate_reg <= 1'b0;
    end
    else
    begin
      crs_out_reg <= dec.carrier & ~ext_strap_reg; // [R12]
      sync_cycle_terminate_reg <= txc_s2_reg & bus_master_i & cfg_ext_bus_reg & bus_mode_strap_strap_reg; // [R10] [R11]
    end
  end

  property p_pins_float;
    @(posedge clk_i) disable iff (rst_i)
    !cfg_written_reg |-> !rx_data_pin_oe_o && !rx_clk_pin_oe_o && !tx_data_pin_oe_o
      && !tx_clk_pin_oe_o;
  endproperty
  a_pins_float: assert property (p_pins_float) else $error("pin driven before config"); // [R8]

  property p_user_drive;
    @(posedge clk_i) disable iff (rst_i)
    cfg_written_reg && cfg_ext_bus_reg && bus_master_i |=> rx_data_pin_oe_o
      && rx_data_pin_o == $past(user_reg[0]) && tx_data_pin_o == $past(user_reg[2]);
  endproperty
  a_user_drive: assert property (p_user_drive) else $error("user output wrong"); // [R9]

  property p_user_float;
    @(posedge clk_i) disable iff (rst_i)
    cfg_written_reg && cfg_ext_bus_reg && !bus_master_i |=> !rx_clk_pin_oe_o;
  endproperty
  a_user_float: assert property (p_user_float) else $error("user output driven as slave"); // [R9]

  property p_tx_clk_pin;
    @(posedge clk_i) disable iff (rst_i)
    !ext_strap_reg && cfg_written_reg && !cfg_ext_bus_reg ##1 !ext_strap_reg && cfg_written_reg
      && !cfg_ext_bus_reg |=> tx_clk_pin_oe_o && tx_clk_pin_o != $past(tx_clk_pin_o);
  endproperty
  a_tx_clk_pin: assert property (p_tx_clk_pin) else $error("tx clock not divided by two"); // [R6]

  property p_txd_at_rise;
    @(posedge clk_i) disable iff (rst_i)
    !ext_strap_reg && $rose(tx_clk_pin_o) && $past(tx_data_pin_oe_o) |-> $stable(tx_data_pin_o);
  endproperty
  a_txd_at_rise: assert property (p_txd_at_rise) else $error("tx data moved at clock rise"); // [R4]

  sequence s_byte_waiting;
    !ext_strap_reg && hold_valid_reg && !tx_active_reg;
  endsequence

  property p_tx_start;
    @(posedge clk_i) disable iff (rst_i)
    s_byte_waiting |-> ##[1:3] tx_active_o;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("transmit enable late"); // [R5]

  property p_tx_hold;
    @(posedge clk_i) disable iff (rst_i)
    tx_active_o && (bit_cnt_reg != 3'h0 || hold_valid_reg && !last_reg) |=> tx_active_o;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("transmit enable dropped mid frame"); // [R5]

  property p_link_byte;
    @(posedge rx_link_clk_i) disable iff (rst_l2_reg)
    link_cnt_reg == 3'h7 |=> link_tog_reg != $past(link_tog_reg)
      && link_byte_reg[7] == $past(rx_data_pin_i);
  endproperty
  a_link_byte: assert property (p_link_byte) else $error("external byte not captured"); // [R2]

  property p_sync_cycle_terminate;
    @(posedge clk_i) disable iff (rst_i)
    sync_cycle_terminate_o |-> $past(bus_master_i) && bus_mode_strap_strap_reg && $past(txc_s2_reg);
  endproperty
  a_sync_cycle_terminate: assert property (p_sync_cycle_terminate) else $error("termination outside master cycle"); // [R10] [R11]

  property p_rxc_route;
    @(posedge clk_i) disable iff (rst_i)
    !ext_strap_reg && cfg_written_reg && !cfg_ext_bus_reg |=> rx_clk_pin_oe_o
      && rx_clk_pin_o == $past(dec.clk) && rx_data_pin_o == $past(dec.data);
  endproperty
  a_rxc_route: assert property (p_rxc_route) else $error("codec signals not on pins"); // [R12]

endmodule

// ### bench/codec_partner.sv
// Behavioural external codec: gated receive link clock and data, transmit clock.
// Assumes the bench enables each clock only while the external codec strap is set.
`timescale 1ns/10ps
module codec_partner (
  input wire logic rx_run_i,
  input wire logic tx_run_i,
  output logic link_clk_o,
  output logic rx_data_o,
  output logic tx_clk_o
);
  int seed = 60;
  // Link clock of 125 ns, parked low between frames
  initial
  begin
    link_clk_o = 1'b0;
    tx_clk_o = 1'b0;
    rx_data_o = 1'b0;
    #17;
    forever
    begin
      #62.5;
      if (rx_run_i || link_clk_o)
        link_clk_o = ~link_clk_o;
      else
        rx_data_o = ~rx_data_o; // Idle line must not hold a stale bit
    end
  end
  // New bit after the fall, so it is steady at the rise
  always @(negedge link_clk_o)
    rx_data_o = 1'($random(seed));
  // Transmit clock of 400 ns, slow enough for the pin synchroniser
  initial
  begin
    #131;
    forever
    begin
      #200;
      if (tx_run_i || tx_clk_o)
        tx_clk_o = ~tx_clk_o;
    end
  end
endmodule

// ### bench/mac_serial_port_test.sv
// Self-checking bench for the MAC serial port: registers, pin roles, serial paths.
// Assumes the codec partner model and the design package are compiled first.
`timescale 1ns/10ps
module mac_serial_port_test;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, external_codec_strap = 1'b0, bus_mode_strap = 1'b0;
  logic master = 1'b0, line = 1'b1, term = 1'b0, xbus = 1'b0, rx_run = 1'b0, tx_run = 1'b0;
  logic tx_last = 1'b0, tx_valid = 1'b0, txc_d = 1'b0, act_d = 1'b0, crs_seen = 1'b0;
  logic [7:0] adr = 8'h00, tx_byte = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
  logic wb_ack_o, rx_data_pin_o, rx_data_pin_oe_o, rx_clk_pin_o, rx_clk_pin_oe_o;
  logic tx_data_pin_o, tx_data_pin_oe_o, tx_clk_pin_o, tx_clk_pin_oe_o, tx_active_o;
  logic carrier_sense_out_o, sync_cycle_terminate_o, tx_ready_o, rx_valid_o;
  logic link_clk, p_rxd, p_txc;
  logic [7:0] rx_byte_o;
  logic q_tx[$], q_exp[$], q_rx[$];
  int mismatches = 0, tests_run = 0, seed = 60, last_end = -1;
  // Pin levels from every driver's enable
  wire rx_pin = rx_data_pin_oe_o ? rx_data_pin_o : p_rxd;
  wire txc_pin = tx_clk_pin_oe_o ? tx_clk_pin_o : (xbus ? term : p_txc);

  mac_serial_port dut (
    .clk_i, .rst_i, .rx_link_clk_i(link_clk), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o, .wb_ack_o,
    .external_codec_strap_i(external_codec_strap), .bus_mode_strap_i(bus_mode_strap), .bus_master_i(master),
    .line_rx_i(line), .rx_data_pin_i(rx_pin), .rx_data_pin_o, .rx_data_pin_oe_o,
    .rx_clk_pin_o, .rx_clk_pin_oe_o, .tx_data_pin_o, .tx_data_pin_oe_o,
    .tx_clk_pin_i(txc_pin), .tx_clk_pin_o, .tx_clk_pin_oe_o, .tx_active_o,
    .carrier_sense_out_o, .sync_cycle_terminate_o, .tx_byte_i(tx_byte),
    .tx_last_i(tx_last), .tx_valid_i(tx_valid), .tx_ready_o, .rx_byte_o, .rx_valid_o
  );
  codec_partner far_end (
    .rx_run_i(rx_run), .tx_run_i(tx_run), .link_clk_o(link_clk), .rx_data_o(p_rxd),
    .tx_clk_o(p_txc)
  );

  // Oscillator clock, 50 ns period
  initial forever #25 clk_i = ~clk_i;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Classic single cycle; held until ack, no assumed latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask

  // With the external strap the link clock runs through a long reset so the link side leaves reset too
  task automatic do_reset(input logic s, input logic b);
    external_codec_strap <= s;
    bus_mode_strap <= b;
    rst_i <= 1'b1;
    rx_run <= s;
    repeat (s ? 10 : 4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic check_oe(input logic [3:0] e);
    repeat (2) @(posedge clk_i);
    check("pin_oe", {rx_data_pin_oe_o, rx_clk_pin_oe_o, tx_data_pin_oe_o, tx_clk_pin_oe_o},
      e);
  endtask

  // Frame of random bytes; the reference is the bit queue, LSB first
  task automatic send(input int n);
    logic [7:0] b;
    // Bytes change only just after a rising edge
    @(posedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      b = 8'($random(seed));
      tx_byte <= b;
      tx_last <= (i == n - 1);
      tx_valid <= 1'b1;
      for (int k = 0; k < 8; k++)
        q_exp.push_back(b[k]);
      do
        @(posedge clk_i);
      while (tx_ready_o !== 1'b1);
    end
    tx_valid <= 1'b0;
    @(negedge tx_active_o);
    repeat (4) @(posedge clk_i);
    check("tx_bits", q_tx.size(), q_exp.size());
    foreach (q_exp[k])
      check("tx_bit", q_tx[k], q_exp[k]);
    q_tx = {};
    q_exp = {};
  endtask

  function automatic logic [7:0] win(input int e);
    logic [7:0] w;
    for (int k = 0; k < 8; k++)
      w[k] = q_rx[e - 7 + k];
    return w;
  endfunction

  // No framing: first byte fixes alignment, later ones must be 8 bits on
  task automatic check_rx();
    int e;
    e = q_rx.size() - 1;
    if (last_end >= 0)
      e = last_end + 8;
    else if (rx_byte_o === win(e - 1))
      e = e - 1;
    last_end = e;
    check("rx_byte", rx_byte_o, win(e));
  endtask

  // Monitors on clk_i sample at its falling edge, where outputs are settled; external codec ones at the partner clock rise
  always @(negedge clk_i)
  begin
    // Pins lag the enable by one cycle, so the enable is delayed to match
    if (!external_codec_strap && act_d === 1'b1 && tx_clk_pin_o && !txc_d)
      q_tx.push_back(tx_data_pin_o);
    txc_d = tx_clk_pin_o;
    act_d = tx_active_o;
    if (carrier_sense_out_o === 1'b1)
      crs_seen = 1'b1;
    if (external_codec_strap && rx_valid_o === 1'b1)
      check_rx();
  end
  always @(posedge p_txc)
    if (external_codec_strap && tx_active_o === 1'b1)
      q_tx.push_back(tx_data_pin_o);
  always @(posedge link_clk)
    if (external_codec_strap)
      q_rx.push_back(rx_pin);

  initial
  begin
    logic p;
    logic [2:0] u;
    do_reset(1'b0, 1'b0);
    check_oe(4'h0);
    wb(1'b0, mac_serial_pkg::ADR_STATUS, 32'h0);
    check("status", rdat, 32'h0);
    wb(1'b1, 8'h0C, $random(seed));
    wb(1'b0, 8'h0C, 32'h0);
    check("unmapped", rdat, 32'h0);
    wb(1'b1, mac_serial_pkg::ADR_CFG, 32'h0);
    check_oe(4'hF);
    for (int i = 0; i < 4; i++)
    begin
      p = tx_clk_pin_o;
      @(negedge clk_i);
      check("tx_clk", tx_clk_pin_o, {~p});
    end
    send(2);
    // Manchester halves, one clock each, then idle high
    for (int i = 0; i < 8; i++)
    begin
      p = 1'($random(seed));
      line <= ~p;
      @(posedge clk_i);
      line <= p;
      @(posedge clk_i);
    end
    line <= 1'b1;
    repeat (20) @(posedge clk_i);
    check("carrier", {crs_seen, carrier_sense_out_o}, 2'b10);
    tx_run <= 1'b1;
    do_reset(1'b1, 1'b1);
    check_oe(4'h0);
    wb(1'b1, mac_serial_pkg::ADR_CFG, 32'h0);
    check_oe(4'h2);
    wb(1'b0, mac_serial_pkg::ADR_STATUS, 32'h0);
    check("status", rdat, 32'h1C);
    send(1);
    tx_run <= 1'b0;
    rx_run <= 1'b0;
    xbus <= 1'b1;
    u = 3'($random(seed));
    wb(1'b1, mac_serial_pkg::ADR_CFG, 32'h1);
    wb(1'b1, mac_serial_pkg::ADR_CFG2, {29'h0, u});
    check_oe(4'h0);
    master <= 1'b1;
    term <= 1'b1;
    check_oe(4'hE);
    check("user", {rx_data_pin_o, rx_clk_pin_o, tx_data_pin_o}, {u[0], u[1], u[2]});
    repeat (3) @(posedge clk_i);
    check("term", sync_cycle_terminate_o, 1'b1);
    master <= 1'b0;
    repeat (5) @(posedge clk_i);
    check("term", sync_cycle_terminate_o, 1'b0);
    report_and_stop();
  end

  // Watchdog well beyond the expected run of about 11 us
  initial
  begin
    #100000;
    mismatches++;
    report_and_stop();
  end
endmodule
